// ### core/sssrw_core.sv
// Purpose: Processor supervisor core: reset generation, watchdog, power-fail flag, RAM supply select
// Assumes: Analog comparators arrive as digital levels; manual reset pad has a pull-up
// Notes:   Reset-hold timer also serves as the power-on reset
//
// Operation
// R1: Any reset trigger holds reset low 200ms
// R2: Supply recovery waits full hold before release
// R3: Brownout asserts reset, restarts hold timer
// R4: Missing toggle within 1.6s triggers reset
// R5: Watchdog cleared by reset or input edge
// R6: Static kick input gives periodic resets
// R7: Watchdog held cleared while reset asserted
// R8: Watchdog cannot be disabled
// R9: Manual reset low asserts, then 200ms hold
// R10: Bouncing manual reset restarts hold each time
// R11: Unconnected manual reset reads inactive high
// R12: Power-fail flag low when sense below level
// R13: Supply below switchover forces flag low
// R14: Power-fail flag independent of reset logic
// R15: Backup selected below switchover with backup above supply, or below 1.75V
// R16: Return to main only above reset level
// R17: Active-high reset is inverse of reset
// R18: Backup mode ignores inputs, holds reset
// R19: Comparators synchronised; intervals are cycle counts
`timescale 1ns/10ps
module sssrw_core
  import sssrw_pkg::*;
#(
  parameter int unsigned HOLD_COUNT = HOLD_CYCLES,
  parameter int unsigned WDOG_COUNT = WDOG_CYCLES
)
(
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic supplyAboveReset,
  input  wire logic supplyAboveSwitch,
  input  wire logic supplyAboveMin,
  input  wire logic backupAboveSupply,
  input  wire logic powerfailSenseIn,
  input  wire logic watchdogKickIn,
  input  wire logic manualResetPadN,
  output logic      cpuResetN,
  output logic      cpuResetOdOe,
  output logic      powerfailFlagN,
  output logic      ramOnBackup
);
  // R19
  localparam int unsigned NSYNC = 7;
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] syncIn;
  logic aboveRst;
  logic aboveSw;
  logic aboveMin;
  logic batHigh;
  logic pfSense;
  logic kick;
  logic manualN;

  // Open pad resolves high through the pull-up, so z reads inactive
  assign rawIn = {supplyAboveReset, supplyAboveSwitch, supplyAboveMin, backupAboveSupply,
                  powerfailSenseIn, watchdogKickIn, manualResetPadN}; // R11

  sssrw_sync #(
    .WIDTH (NSYNC)
  ) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .asyncIn (rawIn),
    .syncOut (syncIn)
  );

  assign {aboveRst, aboveSw, aboveMin, batHigh, pfSense, kick, manualN} = syncIn;

  sssrw_state_type  state_r;
  sssrw_state_type  state_nxt;
  logic             kickPrev_r;
  logic             kickPrev_nxt;
  logic             backup_r;
  logic             backup_nxt;
  logic             resetN_r;
  logic             resetN_nxt;
  logic             pfN_r;
  logic             pfN_nxt;
  logic             odOe_r;
  logic             odOe_nxt;
  logic             holdClear;
  logic             holdDone;
  logic             wdogClear;
  logic             wdogDone;
  logic             trigger;
  logic             kickEdge;

  assign kickEdge = kick ^ kickPrev_r;

  // Level causes that keep reset low; backup also masks the inputs
  assign trigger = !aboveRst || backup_r || (!manualN && !backup_r); // R3 R9 R18

  sssrw_timer #(
    .LIMIT (HOLD_COUNT)
  ) u_hold (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clear   (holdClear),
    .run     (state_r == SSSRW_ST_HOLD),
    .expired (holdDone)
  );

  sssrw_timer #(
    .LIMIT (WDOG_COUNT)
  ) u_wdog (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clear   (wdogClear),
    .run     (state_r == SSSRW_ST_RUN),   // R8
    .expired (wdogDone)
  );

  always_comb
  begin
    state_nxt = state_r;
    holdClear = 1'b0;
    case (state_r)
      SSSRW_ST_ASSERT:
      begin
        holdClear = 1'b1;
        if (!trigger)
          state_nxt = SSSRW_ST_HOLD; // R2 R10
      end
      SSSRW_ST_HOLD:
      begin
        if (trigger)
        begin
          holdClear = 1'b1; // R3 R10
          state_nxt = SSSRW_ST_ASSERT;
        end
        else if (holdDone)
          state_nxt = SSSRW_ST_RUN; // R1
      end
      SSSRW_ST_RUN:
      begin
        holdClear = 1'b1;
        if (trigger)
          state_nxt = SSSRW_ST_ASSERT;
        else if (wdogDone && !kickEdge)
          state_nxt = SSSRW_ST_HOLD; // R4 R6
      end
      default:
      begin
        holdClear = 1'b1;
        state_nxt = SSSRW_ST_ASSERT;
      end
    endcase
  end

  // Cleared throughout reset and by either kick edge; kept off state_nxt to avoid a loop through wdogDone
  assign wdogClear = (state_r != SSSRW_ST_RUN) || kickEdge; // R5 R7

  always_comb
  begin
    kickPrev_nxt = kick;
    resetN_nxt   = (state_nxt == SSSRW_ST_RUN);
    // Open drain: enable high drives the pin low, so drive while reset active
    odOe_nxt     = !resetN_nxt; // R17
    // Recovery back to main supply only past the reset level
    backup_nxt   = backup_r;
    if (!aboveMin || (!aboveSw && batHigh))
      backup_nxt = 1'b1; // R15
    else if (aboveRst)
      backup_nxt = 1'b0; // R16
    // Flag has no path into the reset logic
    pfN_nxt      = aboveSw && pfSense; // R12 R13 R14
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_r    <= SSSRW_ST_ASSERT;
      kickPrev_r <= 1'b0;
      backup_r   <= 1'b0;
      resetN_r   <= 1'b0;
      pfN_r      <= 1'b0;
      odOe_r     <= 1'b1;
    end
    else
    begin
      state_r    <= state_nxt;
      kickPrev_r <= kickPrev_nxt;
      backup_r   <= backup_nxt;
      resetN_r   <= resetN_nxt;
      pfN_r      <= pfN_nxt;
      odOe_r     <= odOe_nxt;
    end
  end

  assign cpuResetN      = resetN_r;
  assign cpuResetOdOe   = odOe_r; // R17
  assign powerfailFlagN = pfN_r;
  assign ramOnBackup    = backup_r;
endmodule : sssrw_core

// ### core/sssrw_sync.sv
// Purpose: Two-flop synchroniser bank for comparator levels
// Assumes: Inputs are static levels between changes
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module sssrw_sync
  import sssrw_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage1_nxt;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage2_nxt;

  always_comb
  begin
    stage1_nxt = asyncIn;
    stage2_nxt = stage1_r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      stage1_r <= {WIDTH{SYNC_RST_VAL}};
      stage2_r <= {WIDTH{SYNC_RST_VAL}};
    end
    else
    begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign syncOut = stage2_r;
endmodule : sssrw_sync

// ### core/sssrw_timer.sv
// Purpose: Restartable interval counter
// Assumes: clear has priority over counting
// Notes:   expired is a level once the count reaches LIMIT - 1 and clear is low
`timescale 1ns/10ps
module sssrw_timer
  import sssrw_pkg::*;
#(
  parameter int unsigned LIMIT = HOLD_CYCLES
)
(
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic clear,
  input  wire logic run,
  output logic      expired
);
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  localparam logic [CNT_W-1:0] LIMIT_C = CNT_W'(LIMIT - 1);

  always_comb
  begin
    count_nxt = count_r;
    if (clear)
      count_nxt = '0;
    else if (run && count_r != LIMIT_C)
      count_nxt = count_r + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      count_r <= '0;
    else
      count_r <= count_nxt;
  end

  assign expired = (count_r == LIMIT_C) && !clear;
endmodule : sssrw_timer

// ### shared/sssrw_pkg.sv
// Purpose: Shared constants for the supply supervisor digital core
// Assumes: 50 MHz system clock
// Notes:   Times kept in their own units, cycle counts derived from them
package sssrw_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned HOLD_MS         = 200;
  localparam int unsigned WDOG_MS         = 1600;
  localparam int unsigned HOLD_CYCLES     = CLK_HZ / 1000 * HOLD_MS;
  localparam int unsigned WDOG_CYCLES     = CLK_HZ / 1000 * WDOG_MS;
  localparam int unsigned CNT_W           = 27;
  localparam int unsigned SYNC_STAGES     = 2;
  localparam logic        SYNC_RST_VAL    = 1'b0;

  typedef enum logic [1:0]
  {
    SSSRW_ST_ASSERT = 2'b00,
    SSSRW_ST_HOLD   = 2'b01,
    SSSRW_ST_RUN    = 2'b10
  } sssrw_state_type;
endpackage : sssrw_pkg

// ### test/sssrw_core_props.sv
// Purpose: Port assertions for the supervisor core
// Assumes: Two-flop input sync, registered outputs
// Notes:   Long spans live in counters, not in repetition
`timescale 1ns/10ps
module sssrw_core_props
#(
  parameter int unsigned HOLD_COUNT = 20,
  parameter int unsigned WDOG_COUNT = 50
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic supplyAboveReset,
  input wire logic supplyAboveSwitch,
  input wire logic supplyAboveMin,
  input wire logic backupAboveSupply,
  input wire logic powerfailSenseIn,
  input wire logic watchdogKickIn,
  input wire logic manualResetPadN,
  input wire logic cpuResetN,
  input wire logic cpuResetOdOe,
  input wire logic powerfailFlagN,
  input wire logic ramOnBackup
);
  int   lowCnt_r;
  int   clrCnt_r;
  int   runCnt_r;
  logic kickD_r;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      kickD_r  <= watchdogKickIn;
      lowCnt_r <= 0;
      runCnt_r <= 0;
      clrCnt_r <= 0;
    end
    else
    begin
      kickD_r  <= watchdogKickIn;
      lowCnt_r <= cpuResetN ? 0 : lowCnt_r + 1;
      // Counts from the raw edge, so it runs ahead of the synchronised one
      runCnt_r <= (!cpuResetN || watchdogKickIn != kickD_r) ? 0 : runCnt_r + 1;
      clrCnt_r <= (!supplyAboveReset || !manualResetPadN || ramOnBackup) ? 0 : clrCnt_r + 1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_OD_INV: assert property (cpuResetOdOe == !cpuResetN)
    else $error("open-drain enable not inverse");
  AST_PF_LOW: assert property (!(supplyAboveSwitch && powerfailSenseIn) |-> ##3 !powerfailFlagN)
    else $error("flag not low");
  AST_BROWN: assert property (!supplyAboveReset |-> ##3 !cpuResetN)
    else $error("no reset on low supply");
  AST_MANUAL: assert property (!manualResetPadN |-> ##3 !cpuResetN)
    else $error("no reset on manual input");
  AST_HOLD: assert property ($rose(cpuResetN) |-> lowCnt_r >= HOLD_COUNT)
    else $error("reset pulse too short");
  AST_RELEASE: assert property (clrCnt_r == HOLD_COUNT + 6 |-> cpuResetN)
    else $error("reset not released");
  AST_WDOG: assert property (runCnt_r <= WDOG_COUNT + 8)
    else $error("watchdog did not fire");
  AST_RAM: assert property (!supplyAboveMin |-> ##3 ramOnBackup)
    else $error("backup not selected");
  cover property ($fell(cpuResetN) && clrCnt_r > 8);
  cover property ($rose(ramOnBackup));
  cover property (!powerfailFlagN && cpuResetN);
endmodule : sssrw_core_props
bind sssrw_core sssrw_core_props #(.HOLD_COUNT(HOLD_COUNT), .WDOG_COUNT(WDOG_COUNT)) i_props (.sys_clk, .sys_rst,
  .supplyAboveReset, .supplyAboveSwitch, .supplyAboveMin, .backupAboveSupply, .powerfailSenseIn,
  .watchdogKickIn, .manualResetPadN, .cpuResetN, .cpuResetOdOe, .powerfailFlagN, .ramOnBackup);

// ### test/sssrw_cpu_model.sv
// Purpose: Processor that services the watchdog
// Assumes: Kicks only while out of reset
// Notes:   kickEn low stands for hung firmware
`timescale 1ns/10ps
module sssrw_cpu_model
(
  input  wire logic sys_clk,
  input  wire logic cpuResetN,
  input  wire logic kickEn,
  output logic      kick = 1'b0
);
  int n = 0;
  always @(posedge sys_clk)
  begin
    n = (cpuResetN && kickEn) ? n + 1 : 0;
    if (n == 10)
    begin
      #1 kick = ~kick;
      n = 0;
    end
  end
endmodule : sssrw_cpu_model

// ### test/test_supply_supervisor_reset_watchdog.sv
// Purpose: Self-checking bench for the supervisor core
// Assumes: Short hold and watchdog counts
// Notes:   Inputs change 1ns after the rising edge
`timescale 1ns/10ps
module test_supply_supervisor_reset_watchdog;
  localparam int unsigned HOLD = 20;
  localparam int unsigned WDOG = 50;
  logic sys_clk = 0, sys_rst = 1, aRst = 1, aSw = 1, aMin = 1, bat = 0, sense = 1, padN = 1, kickEn = 1;
  wire  kick, rstN, odOe, pfN, ram;
  int   bad_count = 0;
  int   comparisons = 0;
  int   lo, hi;
  always #10 sys_clk = ~sys_clk;
  sssrw_core #(.HOLD_COUNT(HOLD), .WDOG_COUNT(WDOG)) i_dut (.sys_clk, .sys_rst, .supplyAboveReset(aRst),
    .supplyAboveSwitch(aSw), .supplyAboveMin(aMin), .backupAboveSupply(bat), .powerfailSenseIn(sense),
    .watchdogKickIn(kick), .manualResetPadN(padN), .cpuResetN(rstN), .cpuResetOdOe(odOe),
    .powerfailFlagN(pfN), .ramOnBackup(ram));
  sssrw_cpu_model i_cpu (.sys_clk, .cpuResetN(rstN), .kickEn, .kick);
  task automatic cy(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cy
  task automatic chk(input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t output differs", $time);
    end
  endtask : chk
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic t_bounce;
    aRst = 0;
    cy(2);
    aRst = 1;
    cy(5);
    chk(rstN, 0);
    cy(12);
    chk(rstN, 0);
    cy(10);
    chk(rstN, 1);
    chk(odOe, 0);
    padN = 0;
    cy(2);
    padN = 1;
    cy(5);
    padN = 0;
    cy(2);
    padN = 1;
    cy(18);
    chk(rstN, 0);
    cy(10);
    chk(rstN, 1);
    $display("bounce done");
  endtask : t_bounce
  task automatic t_wdog;
    cy(200);
    chk(rstN, 1);
    kickEn = 0;
    for (int i = 0; i < 200 && rstN; i++) cy(1);
    for (lo = 0; lo < 200 && !rstN; lo++) cy(1);
    for (hi = 0; hi < 200 && rstN; hi++) cy(1);
    chk(lo >= HOLD, 1);
    chk(lo + hi >= HOLD + WDOG && lo + hi <= HOLD + WDOG + 8, 1);
    kickEn = 1;
    cy(30);
    $display("watchdog done");
  endtask : t_wdog
  task automatic t_supply;
    sense = 0;
    cy(4);
    chk(pfN, 0);
    chk(rstN, 1);
    sense = 1;
    aRst = 0;
    aSw = 0;
    cy(4);
    chk(pfN, 0);
    chk(ram, 0);
    bat = 1;
    cy(4);
    chk(ram, 1);
    chk(rstN, 0);
    aSw = 1;
    bat = 0;
    cy(4);
    chk(ram, 1);
    chk(pfN, 1);
    aRst = 1;
    cy(4);
    chk(ram, 0);
    aMin = 0;
    cy(4);
    chk(ram, 1);
    chk(rstN, 0);
    aMin = 1;
    cy(30);
    $display("supply done");
  endtask : t_supply
  initial
  begin
    cy(10);
    sys_rst = 0;
    cy(10);
    chk(rstN, 0);
    chk(odOe, 1);
    cy(20);
    chk(rstN, 1);
    t_bounce();
    t_wdog();
    t_supply();
    complete_run();
  end
  initial
  begin
    #400000;
    bad_count++;
    complete_run();
  end
endmodule : test_supply_supervisor_reset_watchdog
